// *** verilog/qcs_top.sv ***
// Four-channel 32-bit counter core with capture, time stamp and status
// read-out, serving requests from the module manager over the module port.
// Assumes requests and events are synchronous to i_clk.
`timescale 1ns/1ps

module qcs_top
  import qcs_pkg::*;
(
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_resetn,
  // Module port request
  input  wire qcs_req_s                     i_req,
  // Per-channel counter events
  input  wire qcs_evt_s [QCS_NCH-1:0]       i_evt,
  // Per-channel first initial value register contents
  input  wire logic [QCS_NCH-1:0][QCS_CW-1:0] i_preload,
  // Time stamp base
  input  wire logic [QCS_TW-1:0]            i_tbase,
  // Module port answer
  output qcs_rsp_s                          o_rsp
);

  qcs_state_s state_ff;
  qcs_state_s nxt_state;

  // Assemble the status word of one channel
  function automatic logic [QCS_SW-1:0] status_word(input qcs_chan_s c);
    logic [QCS_SW-1:0] w;
    w = '0;
    w[QCS_B_FAULT] = c.fault;
    w[QCS_B_CAPD]  = c.capd;
    w[QCS_B_GO]    = c.go;
    w[QCS_B_LOD]   = c.preloaded_flag;
    w[QCS_B_EXT]   = c.core[QCS_CW];
    w[QCS_B_UF]    = c.uf;
    w[QCS_B_OF]    = c.of;
    w[QCS_B_NULL]  = (c.core[QCS_CW-1:0] == QCS_CNT_ZERO);
    return w;
  endfunction : status_word

  // One step of the 33-bit core, up or down
  function automatic logic [QCS_CW:0] step(input logic [QCS_CW:0] v,
                                           input logic dn);
    logic [QCS_CW:0] r;
    r = '0;
    if (dn) begin
      r = v - 33'h0_0000_0001;
    end else begin
      r = v + 33'h0_0000_0001;
    end
    return r;
  endfunction : step

  // Request decode
  logic rd_counts;
  logic rd_status;
  logic wr_ctrl;
  logic ctrl_load;
  logic ctrl_capture;

  always_comb begin
    rd_counts    = i_req.valid && (i_req.op == QCS_OP_COUNTS);
    rd_status    = i_req.valid && (i_req.op == QCS_OP_STATUS);
    wr_ctrl      = i_req.valid && (i_req.op == QCS_OP_CONTROL);
    ctrl_load    = wr_ctrl && (i_req.code == QCS_LOAD_CORE_CMD);
    ctrl_capture = wr_ctrl && (i_req.code == QCS_CAPTURE_CORE_CMD);
  end

  // Next state of all channels and of the answer
  always_comb begin
    qcs_chan_s c;
    logic      sel;
    c = '0;
    sel = 1'b0;
    nxt_state = state_ff;
    for (int i = 0; i < QCS_NCH; i++) begin
      c = state_ff.ch[i];
      sel = (i_req.chan == QCS_CHW'(i));
      if (rd_status && sel) begin
        c.fault = 1'b0;
        c.preloaded_flag   = 1'b0;
        c.uf    = 1'b0;
        c.of    = 1'b0;
      end
      if (rd_counts && sel) begin
        c.capd = 1'b0;
      end
      if ((ctrl_capture && sel) || i_evt[i].auto_cap) begin
        c.cap  = state_ff.ch[i].core[QCS_CW-1:0];
        c.ts   = i_tbase;
        c.capd = 1'b1;
      end
      if (ctrl_load && sel) begin
        c.core = {1'b0, i_preload[i]};
        c.preloaded_flag  = 1'b1;
      end else if (i_evt[i].up && !i_evt[i].dn) begin
        c.core = step(state_ff.ch[i].core, 1'b0);
        if (state_ff.ch[i].core[QCS_CW-1:0] == QCS_CNT_MAX) begin
          c.of = 1'b1;
        end
      end else if (i_evt[i].dn && !i_evt[i].up) begin
        c.core = step(state_ff.ch[i].core, 1'b1);
        if (state_ff.ch[i].core[QCS_CW-1:0] == QCS_CNT_ZERO) begin
          c.uf = 1'b1;
        end
      end
      if (i_evt[i].fault) begin
        c.fault = 1'b1;
      end
      if (i_evt[i].go_trig) begin
        c.go = 1'b1;
      end
      nxt_state.ch[i] = c;
    end
    // Answer is a one-cycle pulse per request
    nxt_state.rsp.valid  = i_req.valid;
    nxt_state.rsp.err    = wr_ctrl && !ctrl_load && !ctrl_capture;
    nxt_state.rsp.counts = QCS_CNT_ZERO;
    nxt_state.rsp.tstamp = QCS_TS_ZERO;
    nxt_state.rsp.status = '0;
    if (rd_counts) begin
      nxt_state.rsp.counts = state_ff.ch[i_req.chan].cap;
      if (i_req.want_ts) begin
        nxt_state.rsp.tstamp = state_ff.ch[i_req.chan].ts;
      end
    end
    if (rd_status) begin
      nxt_state.rsp.status = status_word(state_ff.ch[i_req.chan]);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < QCS_NCH; i++) begin
        state_ff.ch[i].core  <= QCS_CORE_RST;
        state_ff.ch[i].cap   <= QCS_CNT_ZERO;
        state_ff.ch[i].ts    <= QCS_TS_ZERO;
        state_ff.ch[i].fault <= 1'b0;
        state_ff.ch[i].capd  <= 1'b0;
        state_ff.ch[i].go    <= 1'b0;
        state_ff.ch[i].preloaded_flag   <= 1'b0;
        state_ff.ch[i].uf    <= 1'b0;
        state_ff.ch[i].of    <= 1'b0;
      end
      state_ff.rsp <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Answer straight from the state register
  assign o_rsp = state_ff.rsp;

  // Channel 0 request helpers for the checks
  logic ch0_st;
  logic ch0_ct;
  logic ch0_ld;
  logic ch0_cp;
  assign ch0_st = rd_status && (i_req.chan == QCS_CHW'(0));
  assign ch0_ct = rd_counts && (i_req.chan == QCS_CHW'(0));
  assign ch0_ld = ctrl_load && (i_req.chan == QCS_CHW'(0));
  assign ch0_cp = ctrl_capture && (i_req.chan == QCS_CHW'(0));

  // Reserved status bits read zero
  rsv_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_rsp.valid |-> o_rsp.status[QCS_SW-1:QCS_DW] == '0)
    else $error("reserved status bits not zero");

  // Decoder fault survives a same-cycle status read
  fault_wins_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_evt[0].fault |=> state_ff.ch[0].fault)
    else $error("decoder fault not set");

  // Counts read clears capture flag
  capd_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_ct && !i_evt[0].auto_cap |=> !state_ff.ch[0].capd)
    else $error("capture flag not cleared");

  // Trigger enable is set and held
  go_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_evt[0].go_trig |=> state_ff.ch[0].go [*2])
    else $error("trigger flag lost");

  // Load takes preload value and flags it
  load_core_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_ld |=> state_ff.ch[0].preloaded_flag &&
      state_ff.ch[0].core[QCS_CW-1:0] == $past(i_preload[0]))
    else $error("preload not taken");

  // Extension bit reported in status
  ext_bit_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st |=> o_rsp.status[QCS_B_EXT] == $past(state_ff.ch[0].core[QCS_CW]))
    else $error("extension bit wrong");

  // Overflow set on upward wrap
  ovf_set_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    state_ff.ch[0].core[QCS_CW-1:0] == QCS_CNT_MAX && i_evt[0].up &&
      !i_evt[0].dn && !ch0_ld |=> state_ff.ch[0].of &&
      state_ff.ch[0].core[QCS_CW-1:0] == QCS_CNT_ZERO)
    else $error("overflow not flagged");

  // Zero bit follows the live count
  null_bit_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st |=> o_rsp.status[QCS_B_NULL] ==
      ($past(state_ff.ch[0].core[QCS_CW-1:0]) == QCS_CNT_ZERO))
    else $error("zero bit wrong");

  // Counts read returns the capture register
  counts_val_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_ct |=> o_rsp.valid && o_rsp.counts == $past(state_ff.ch[0].cap))
    else $error("counts not from capture register");

  // Status read clears underflow unless a new one arrives
  uf_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st && !(i_evt[0].dn && !i_evt[0].up) |=> !state_ff.ch[0].uf)
    else $error("underflow not cleared");

  // Status read clears the preloaded flag
  lod_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st |=> !state_ff.ch[0].preloaded_flag)
    else $error("preloaded flag not cleared");

  // Status read clears overflow unless a new one arrives
  of_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st && !(i_evt[0].up && !i_evt[0].dn) |=> !state_ff.ch[0].of)
    else $error("overflow not cleared");

  // Status read clears decoder fault unless a new one arrives
  fault_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_st && !i_evt[0].fault |=> !state_ff.ch[0].fault)
    else $error("decoder fault not cleared");

  // Underflow set on downward wrap
  uf_set_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    state_ff.ch[0].core[QCS_CW-1:0] == QCS_CNT_ZERO && i_evt[0].dn &&
      !i_evt[0].up && !ch0_ld |=> state_ff.ch[0].uf &&
      state_ff.ch[0].core[QCS_CW-1:0] == QCS_CNT_MAX)
    else $error("underflow not flagged");

  // Capture command copies the core and flags it
  capd_set_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_cp |=> state_ff.ch[0].capd &&
      state_ff.ch[0].cap == $past(state_ff.ch[0].core[QCS_CW-1:0]))
    else $error("capture command not taken");

  // Automatic capture takes the time stamp base
  auto_cap_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_evt[0].auto_cap |=> state_ff.ch[0].capd &&
      state_ff.ch[0].ts == $past(i_tbase))
    else $error("automatic capture not taken");

  // Time stamp returned only when asked
  ts_read_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ch0_ct |=> o_rsp.tstamp ==
      ($past(i_req.want_ts) ? $past(state_ff.ch[0].ts) : QCS_TS_ZERO))
    else $error("time stamp answer wrong");

  // Unknown control code is flagged
  bad_code_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    wr_ctrl && !ctrl_load && !ctrl_capture |=> o_rsp.valid && o_rsp.err)
    else $error("unknown code not flagged");

  // Status answer comes from the addressed channel
  chan_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    rd_status && i_req.chan == QCS_CHW'(3) |=>
      o_rsp.status[QCS_B_GO] == $past(state_ff.ch[3].go) &&
      o_rsp.status[QCS_B_FAULT] == $past(state_ff.ch[3].fault))
    else $error("status from wrong channel");

endmodule : qcs_top

// *** inc/qcs_pkg.sv ***
// Shared types and constants for the four-channel counter read-out block.
// Assumes one clock domain; the event inputs come from logic on that clock.
package qcs_pkg;

  // Geometry
  localparam int QCS_NCH = 4;
  localparam int QCS_CHW = 2;
  localparam int QCS_CW  = 32;
  localparam int QCS_TW  = 16;
  localparam int QCS_SW  = 16;
  localparam int QCS_DW  = 8;

  // Status word bit positions
  localparam int QCS_B_FAULT = 7;
  localparam int QCS_B_CAPD  = 6;
  localparam int QCS_B_GO    = 5;
  localparam int QCS_B_LOD   = 4;
  localparam int QCS_B_EXT   = 3;
  localparam int QCS_B_UF    = 2;
  localparam int QCS_B_OF    = 1;
  localparam int QCS_B_NULL  = 0;

  // Command codes
  localparam logic [QCS_DW-1:0] QCS_LOAD_CORE_CMD    = 8'h01;
  localparam logic [QCS_DW-1:0] QCS_CAPTURE_CORE_CMD = 8'h02;

  // Reset and fill values
  localparam logic [QCS_CW:0]   QCS_CORE_RST = 33'h0_0000_0000;
  localparam logic [QCS_CW-1:0] QCS_CNT_MAX  = 32'hffff_ffff;
  localparam logic [QCS_CW-1:0] QCS_CNT_ZERO = 32'h0000_0000;
  localparam logic [QCS_TW-1:0] QCS_TS_ZERO  = 16'h0000;

  // Request kinds, one-hot
  typedef enum logic [2:0] {
    QCS_OP_COUNTS  = 3'h1,
    QCS_OP_STATUS  = 3'h2,
    QCS_OP_CONTROL = 3'h4
  } qcs_op_e;

  typedef struct packed {
    logic              valid;
    qcs_op_e           op;
    logic [QCS_CHW-1:0] chan;
    logic [QCS_DW-1:0] code;
    logic              want_ts;
  } qcs_req_s;

  typedef struct packed {
    logic              valid;
    logic              err;
    logic [QCS_CW-1:0] counts;
    logic [QCS_TW-1:0] tstamp;
    logic [QCS_SW-1:0] status;
  } qcs_rsp_s;

  // Per-channel single-cycle events from the decoder and trigger logic
  typedef struct packed {
    logic up;
    logic dn;
    logic fault;
    logic go_trig;
    logic auto_cap;
  } qcs_evt_s;

  typedef struct packed {
    logic [QCS_CW:0]   core;
    logic [QCS_CW-1:0] cap;
    logic [QCS_TW-1:0] ts;
    logic              fault;
    logic              capd;
    logic              go;
    logic              preloaded_flag;
    logic              uf;
    logic              of;
  } qcs_chan_s;

  typedef struct packed {
    qcs_chan_s [QCS_NCH-1:0] ch;
    qcs_rsp_s                rsp;
  } qcs_state_s;

endpackage : qcs_pkg

// *** sim/qcs_gateway_model.sv ***
// Gateway model: issues one request and returns the answer.
// Assumes the block samples requests on the rising edge.
`timescale 1ns/1ps
module qcs_gateway_model
  import qcs_pkg::*;
(
  // Clock and answer
  input  wire logic     i_clk,
  input  wire qcs_rsp_s i_rsp,
  // Request out
  output qcs_req_s      o_req
);
  // Idle until the first request
  initial o_req = '0;

  task automatic xact(input qcs_op_e op, input logic [1:0] ch,
                      input logic [7:0] code, input logic ts,
                      output qcs_rsp_s rsp);
    qcs_req_s req;
    req = '{valid: 1'b1, op: op, chan: ch, code: code, want_ts: ts};
    @(negedge i_clk);
    o_req <= req;
    @(negedge i_clk);
    rsp = i_rsp;
    // Released fields show junk, not the old value
    req = qcs_req_s'(~req);
    req.valid = 1'b0;
    o_req <= req;
  endtask : xact
endmodule : qcs_gateway_model

// *** sim/quad_counter_status_capture_test.sv ***
// Self-checking bench for the counter read-out block.
// Assumes the gateway model drives requests on falling edges.
`timescale 1ns/1ps
module quad_counter_status_capture_test;
  import qcs_pkg::*;
  logic                           i_clk;
  logic                           i_resetn;
  qcs_req_s                       req;
  qcs_evt_s [QCS_NCH-1:0]         evt;
  logic [QCS_NCH-1:0][QCS_CW-1:0] pre;
  logic [QCS_TW-1:0]              tbase;
  qcs_rsp_s                       rsp;
  qcs_rsp_s                       r;
  int                             num_errors;
  int                             check_count;
  localparam qcs_evt_s UP = 5'h10, DN = 5'h08, FLT = 5'h04;
  localparam qcs_evt_s GO = 5'h02, ACAP = 5'h01;

  qcs_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req),
    .i_evt(evt), .i_preload(pre), .i_tbase(tbase), .o_rsp(rsp));
  qcs_gateway_model gw_u (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));

  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string n, logic e, logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit

  task automatic pulse(input int ch, input qcs_evt_s e);
    @(negedge i_clk);
    evt[ch] <= e;
    @(negedge i_clk);
    evt <= '0;
  endtask : pulse

  task automatic stat(input logic [1:0] ch, input logic [15:0] e);
    gw_u.xact(QCS_OP_STATUS, ch, 8'h00, 1'b0, r);
    chk_bit("valid", 1'b1, r.valid);
    chk_val("status", {16'h0000, e}, {16'h0000, r.status});
  endtask : stat

  task automatic ctl(input logic [1:0] ch, input logic [7:0] c,
                     input logic e);
    gw_u.xact(QCS_OP_CONTROL, ch, c, 1'b0, r);
    chk_bit("valid", 1'b1, r.valid);
    chk_bit("err", e, r.err);
  endtask : ctl

  task automatic cnt(input logic [1:0] ch, input logic ts,
                     input logic [31:0] e, input logic [15:0] t);
    gw_u.xact(QCS_OP_COUNTS, ch, 8'h00, ts, r);
    chk_bit("valid", 1'b1, r.valid);
    chk_val("counts", e, r.counts);
    chk_val("tstamp", {16'h0000, t}, {16'h0000, r.tstamp});
  endtask : cnt

  task automatic t_reset;
    for (int c = 0; c < QCS_NCH; c++) begin
      stat(c[1:0], 16'h0001);
    end
  endtask : t_reset

  task automatic t_load_wrap;
    ctl(2'd2, QCS_LOAD_CORE_CMD, 1'b0);
    stat(2'd2, 16'h0010);
    stat(2'd2, 16'h0000);
    pulse(2, UP);
    stat(2'd2, 16'h000b);
    stat(2'd2, 16'h0009);
    pulse(2, DN);
    stat(2'd2, 16'h0004);
    stat(2'd2, 16'h0000);
  endtask : t_load_wrap

  task automatic t_capture;
    ctl(2'd2, QCS_CAPTURE_CORE_CMD, 1'b0);
    stat(2'd2, 16'h0040);
    cnt(2'd2, 1'b1, 32'hffff_ffff, 16'h1234);
    pulse(2, UP);
    cnt(2'd2, 1'b0, 32'hffff_ffff, 16'h0000);
    stat(2'd2, 16'h000b);
    pulse(1, ACAP);
    stat(2'd1, 16'h0041);
    cnt(2'd1, 1'b1, 32'h0000_0000, 16'h1234);
  endtask : t_capture

  task automatic t_fault_go;
    pulse(3, qcs_evt_s'(FLT | GO));
    stat(2'd3, 16'h00a1);
    stat(2'd3, 16'h0021);
    fork
      pulse(3, FLT);
      stat(2'd3, 16'h0021);
    join
    stat(2'd3, 16'h00a1);
  endtask : t_fault_go

  task automatic t_bad_code;
    ctl(2'd0, 8'h03, 1'b1);
    ctl(2'd0, 8'h00, 1'b1);
    stat(2'd0, 16'h0001);
  endtask : t_bad_code

  // Channel 0 walk, so the design's channel 0 checks all fire
  task automatic t_chan0;
    ctl(2'd0, QCS_LOAD_CORE_CMD, 1'b0);
    pulse(0, qcs_evt_s'(UP | GO));
    stat(2'd0, 16'h003b);
    fork
      pulse(0, FLT);
      stat(2'd0, 16'h0029);
    join
    stat(2'd0, 16'h00a9);
    pulse(0, DN);
    ctl(2'd0, QCS_CAPTURE_CORE_CMD, 1'b0);
    stat(2'd0, 16'h0064);
    cnt(2'd0, 1'b1, 32'hffff_ffff, 16'h1234);
    stat(2'd0, 16'h0020);
    pulse(0, qcs_evt_s'(UP | ACAP));
    stat(2'd0, 16'h006b);
  endtask : t_chan0

  task automatic tally_and_finish;
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    i_resetn = 1'b0;
    evt = '0;
    pre = '0;
    pre[2] = 32'hffff_ffff;
    pre[0] = 32'hffff_ffff;
    tbase = 16'h1234;
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    t_reset();
    t_load_wrap();
    t_capture();
    t_fault_go();
    t_bad_code();
    t_chan0();
    tally_and_finish();
  end

  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
endmodule : quad_counter_status_capture_test
